/* File: rtl/dctc_top.sv */
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Byte and word counter/timer control with Wishbone register access
module dctc_top
	import dctc_pkg::*;
#(
	parameter int DIV_W = 3  // Width of word timer prescaler
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Stop-mode recovery pulse
	input  wire logic        stopRecover,
	// Pins and port data
	input  wire logic        pin31_input,
	input  wire logic        pin20_input,
	input  wire logic        portData34,
	input  wire logic        portData35,
	input  wire logic        portData36,
	output logic             pin34Out,
	output logic             pin35Out,
	output logic             pin36Out,
	// Interrupt requests
	output logic             byteCaptureIrq,
	output logic             byteTimeoutIrq,
	output logic             wordCaptureIrq,
	output logic             wordTimeoutIrq
);
	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0]  timer_common_control_q;  // Shared control
	logic [7:0]  byteCtrl_q;              // Byte timer control
	logic [7:0]  wordCtrl_q;              // Word timer control
	logic [7:0]  byte_capture_low_q;      // Byte capture, rising edge
	logic [7:0]  byte_capture_high_q;     // Byte capture, falling edge
	logic [7:0]  word_capture_low_q;      // Word capture, low byte
	logic [7:0]  word_capture_high_q;     // Word capture, high byte
	logic [7:0]  byteReload_q;            // Byte transmit reload
	logic [15:0] wordReload_q;            // Word transmit reload
	logic [7:0]  byteCount_q;             // Byte counter
	logic [15:0] wordCount_q;             // Word counter
	logic        byteOut_q;               // Byte timer output
	logic        wordOut_q;               // Word timer output
	logic        wordFirstDone_q;         // First edge taken
	logic [DIV_W-1:0] div_q;              // Prescaler
	logic        demodPrev_q;             // Previous demod level
	logic        ack_q;                   // Bus acknowledge
	logic [7:0]  rdData_q;                // Read data
	logic        pin34_q;                 // Pin 34 register
	logic        pin35_q;                 // Pin 35 register
	logic        pin36_q;                 // Pin 36 register
	logic        pin31Level;              // Synchronised pin 31
	logic        pin20Level;              // Synchronised pin 20

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	dctc_sync u_sync31 (
		.clk   (clk),
		.rst_b (rst_b),
		.pinIn (pin31_input),
		.level (pin31Level)
	);
	dctc_sync u_sync20 (
		.clk   (clk),
		.rst_b (rst_b),
		.pinIn (pin20_input),
		.level (pin20Level)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire       busReq   = wb_cyc_i & wb_stb_i;
	wire [3:0] regIdx   = wb_adr_i[5:2];
	wire       inRange  = (wb_adr_i[31:6] == 26'h0) & (wb_adr_i[1:0] == 2'b00);
	wire       wrStrobe = busReq & ack_q & wb_we_i & wb_sel_i[0] & inRange;
	wire [7:0] wrByte   = wb_dat_i[7:0];
	wire       wrCommon = wrStrobe & (regIdx == IDX_COMMON_CTRL);
	wire       wrByteC  = wrStrobe & (regIdx == IDX_BYTE_CTRL);
	wire       wrWordC  = wrStrobe & (regIdx == IDX_WORD_CTRL);
	wire       wrByteR  = wrStrobe & (regIdx == IDX_BYTE_RELOAD);
	wire       wrWordL  = wrStrobe & (regIdx == IDX_WORD_REL_LO);
	wire       wrWordH  = wrStrobe & (regIdx == IDX_WORD_REL_HI);

	////////////////////////////////////////////////////////////////////////
	// Control field taps
	wire       demodMode  = timer_common_control_q[COM_MODE_BIT];  // R1
	wire       selBit     = timer_common_control_q[COM_SEL_BIT];
	wire [1:0] funcField  = timer_common_control_q[COM_FUNC_LSB +: 2];
	wire       byteEn     = byteCtrl_q[BC_ENABLE_BIT];
	wire       wordEn     = wordCtrl_q[WC_ENABLE_BIT];
	wire       wordPolicy = wordCtrl_q[WC_POLICY_BIT];
	wire [1:0] clkSel     = wordCtrl_q[WC_CLKSEL_LSB +: 2];

	////////////////////////////////////////////////////////////////////////
	// Demodulator input and edge detect
	wire demodIn  = selBit ? pin20Level : pin31Level;  // R2
	wire riseSeen = demodIn & ~demodPrev_q;
	wire fallSeen = ~demodIn & demodPrev_q;
	logic edgeHit;  // Selected edge detected
	// Edge choice by field code
	always_comb begin
		unique case (dctc_edge_t'(funcField))
			DCTC_EDGE_FALL: edgeHit = fallSeen;             // R4
			DCTC_EDGE_RISE: edgeHit = riseSeen;             // R4
			DCTC_EDGE_BOTH: edgeHit = riseSeen | fallSeen;  // R4
			DCTC_EDGE_RSVD: edgeHit = 1'b0;                 // R4
		endcase
	end
	wire demodEdge = demodMode & edgeHit;

	////////////////////////////////////////////////////////////////////////
	// Word timer prescaler
	// Low prescaler bits that must be zero: divide by 1, 2, 4 or 8
	wire [DIV_W-1:0] divMask  = DIV_W'((4'h1 << clkSel) - 4'h1);
	wire             wordTick = ((div_q & divMask) == DIV_W'(0));  // R7

	////////////////////////////////////////////////////////////////////////
	// Timer events
	wire byteTimeout = byteEn & (byteCount_q == 8'h00);
	wire byteCapture = byteEn & demodEdge;
	wire wordTimeout = wordEn & wordTick & (wordCount_q == 16'h0000);
	wire wordTaken   = wordEn & demodEdge & (~wordPolicy | ~wordFirstDone_q);  // R5
	wire wordCapture = wordTaken;

	////////////////////////////////////////////////////////////////////////
	// Requests: event AND mask
	assign byteCaptureIrq = byteCapture & byteCtrl_q[BC_CAPMASK_BIT];  // R11 R16
	assign byteTimeoutIrq = byteTimeout & byteCtrl_q[BC_CNTMASK_BIT];  // R12 R16
	assign wordCaptureIrq = wordCapture & wordCtrl_q[WC_CAPMASK_BIT];  // R8 R16
	assign wordTimeoutIrq = wordTimeout & wordCtrl_q[WC_CNTMASK_BIT];  // R9 R16

	////////////////////////////////////////////////////////////////////////
	// Output combining
	logic combined;  // Combined timer output
	// Logic function by field code
	always_comb begin
		unique case (dctc_comb_t'(funcField))
			DCTC_COMB_AND:  combined = byteOut_q & wordOut_q;     // R3
			DCTC_COMB_OR:   combined = byteOut_q | wordOut_q;     // R3
			DCTC_COMB_NOR:  combined = ~(byteOut_q | wordOut_q);  // R3
			DCTC_COMB_NAND: combined = ~(byteOut_q & wordOut_q);  // R3
		endcase
	end
	wire pin36Next = (~demodMode & selBit) ? combined : portData36;  // R2
	wire pin34Next = byteCtrl_q[BC_PINSEL_BIT] ? byteOut_q : portData34;  // R13
	wire pin35Next = wordCtrl_q[WC_PINSEL_BIT] ? wordOut_q : portData35;  // R10

	////////////////////////////////////////////////////////////////////////
	// Flag next values; a set wins over a same-cycle clear
	wire byteFlagD = byteTimeout |
		(byteCtrl_q[BC_TIMEOUT_BIT] & ~(wrByteC & wrByte[BC_TIMEOUT_BIT]));
	wire wordFlagD = wordTimeout |
		(wordCtrl_q[WC_TIMEOUT_BIT] & ~(wrWordC & wrByte[WC_TIMEOUT_BIT]));  // R6

	////////////////////////////////////////////////////////////////////////
	// Read mux
	logic [7:0] rdMux;  // Selected register
	// Unmapped indexes read zero
	always_comb begin
		rdMux = 8'h00;
		if (inRange) begin
			case (regIdx)
				IDX_BYTE_CTRL:   rdMux = byteCtrl_q;
				IDX_COMMON_CTRL: rdMux = timer_common_control_q;
				IDX_WORD_CTRL:   rdMux = wordCtrl_q;
				IDX_BYTE_CAP_LO: rdMux = byte_capture_low_q;
				IDX_BYTE_CAP_HI: rdMux = byte_capture_high_q;
				IDX_WORD_CAP_LO: rdMux = word_capture_low_q;
				IDX_WORD_CAP_HI: rdMux = word_capture_high_q;
				IDX_BYTE_RELOAD: rdMux = byteReload_q;
				IDX_WORD_REL_LO: rdMux = wordReload_q[7:0];
				IDX_WORD_REL_HI: rdMux = wordReload_q[15:8];
				default:         rdMux = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus handshake: one-wait-state ack, dropped after one cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q    <= 1'b0;
			rdData_q <= 8'h00;
		end else begin
			ack_q    <= busReq & ~ack_q;
			rdData_q <= rdMux;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = {24'h000000, rdData_q};

	////////////////////////////////////////////////////////////////////////
	// Common control register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_common_control_q <= COMMON_RESET;  // R1
		end else if (wrCommon) begin
			timer_common_control_q <= {wrByte[7:4], 4'h0};
		end else if (stopRecover) begin
			// Mode and select return to default, combine/edge field kept
			timer_common_control_q <= {COMMON_RESET[7:6], funcField, 4'h0};  // R15
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer control registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			byteCtrl_q <= BYTE_CTRL_RESET;
			wordCtrl_q <= WORD_CTRL_RESET;
		end else begin
			byteCtrl_q[BC_TIMEOUT_BIT] <= byteFlagD;
			wordCtrl_q[WC_TIMEOUT_BIT] <= wordFlagD;  // R6
			if (wrByteC) begin
				byteCtrl_q[7:6] <= wrByte[7:6];
				byteCtrl_q[4:0] <= wrByte[4:0];
			end
			if (wrWordC) begin
				wordCtrl_q[7:6] <= wrByte[7:6];
				wordCtrl_q[4:0] <= wrByte[4:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reload registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			byteReload_q <= BYTE_RELOAD_RESET;
			wordReload_q <= WORD_RELOAD_RESET;
		end else begin
			if (wrByteR) byteReload_q <= wrByte;
			if (wrWordL) wordReload_q[7:0] <= wrByte;
			if (wrWordH) wordReload_q[15:8] <= wrByte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte timer: count, capture and reload
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			byteCount_q         <= BYTE_RELOAD_RESET;
			byteOut_q           <= 1'b0;
			byte_capture_low_q  <= 8'h00;
			byte_capture_high_q <= 8'h00;
		end else if (!byteEn) begin
			byteCount_q <= demodMode ? BYTE_DEMOD_LOAD : byteReload_q;
		end else if (byteCapture) begin
			if (fallSeen) begin
				byte_capture_high_q <= byteCount_q;  // R14
			end else begin
				byte_capture_low_q <= byteCount_q;  // R11
			end
			byteCount_q <= BYTE_DEMOD_LOAD;  // R14
		end else if (byteTimeout) begin
			byteCount_q <= demodMode ? BYTE_DEMOD_LOAD : byteReload_q;
			byteOut_q   <= ~byteOut_q;
		end else begin
			byteCount_q <= byteCount_q - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Word timer: prescaled count, capture and reload
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_q               <= DIV_W'(0);
			wordCount_q         <= WORD_RELOAD_RESET;
			wordOut_q           <= 1'b0;
			wordFirstDone_q     <= 1'b0;
			word_capture_low_q  <= 8'h00;
			word_capture_high_q <= 8'h00;
		end else if (!wordEn) begin
			div_q           <= DIV_W'(0);
			wordFirstDone_q <= 1'b0;
			wordCount_q     <= demodMode ? WORD_DEMOD_LOAD : wordReload_q;
		end else begin
			div_q <= div_q + DIV_W'(1);
			if (wordTaken) begin
				word_capture_low_q  <= wordCount_q[7:0];   // R8
				word_capture_high_q <= wordCount_q[15:8];  // R8
				wordCount_q         <= WORD_DEMOD_LOAD;    // R5
				wordFirstDone_q     <= 1'b1;               // R5
			end else if (wordTimeout) begin
				wordCount_q <= demodMode ? WORD_DEMOD_LOAD : wordReload_q;
				wordOut_q   <= ~wordOut_q;
			end else if (wordTick) begin
				wordCount_q <= wordCount_q - 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Edge history and registered pins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			demodPrev_q <= 1'b0;
			pin34_q     <= 1'b0;
			pin35_q     <= 1'b0;
			pin36_q     <= 1'b0;
		end else begin
			demodPrev_q <= demodIn;
			pin34_q     <= pin34Next;  // R13
			pin35_q     <= pin35Next;  // R10
			pin36_q     <= pin36Next;  // R2
		end
	end
	assign pin34Out = pin34_q;
	assign pin35Out = pin35_q;
	assign pin36Out = pin36_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_mode_write: assert property (wrCommon |=> demodMode == $past(wb_dat_i[7]))  // R1
		else $error("mode bit not taken from write");
	a_pin36_route: assert property (!demodMode && selBit |=> pin36Out == $past(combined))  // R2
		else $error("pin36 not driving combined output");
	a_comb_nand: assert property (funcField == 2'b11 |-> combined == ~(byteOut_q & wordOut_q))  // R3
		else $error("nand combine wrong");
	a_edge_rsvd: assert property (funcField == 2'b11 && demodMode |-> !demodEdge)  // R4
		else $error("reserved edge code detected an edge");
	a_first_only: assert property (wordPolicy && wordFirstDone_q |-> !wordCapture)  // R5
		else $error("word timer captured after first edge");
	a_flag_sets: assert property (wordTimeout |=> wordCtrl_q[WC_TIMEOUT_BIT])  // R6
		else $error("timeout flag not set");
	a_flag_clear: assert property (wrWordC && wb_dat_i[5] && !wordTimeout  // R6
		|=> !wordCtrl_q[WC_TIMEOUT_BIT])
		else $error("timeout flag not cleared");
	a_word_irq: assert property (wordCaptureIrq |=>  // R8
		{word_capture_high_q, word_capture_low_q} == $past(wordCount_q))
		else $error("capture request without capture");
	a_mask_gate: assert property (!wordCtrl_q[WC_CNTMASK_BIT] |-> !wordTimeoutIrq)  // R9
		else $error("masked timeout requested");
	a_pin35_route: assert property (wordCtrl_q[WC_PINSEL_BIT] |=> pin35Out == $past(wordOut_q))  // R10
		else $error("pin35 routing wrong");
	a_byte_irq: assert property (byteCaptureIrq |-> demodMode && byteCtrl_q[BC_CAPMASK_BIT])  // R11
		else $error("byte capture request outside demod");
	a_byte_tmo: assert property (byteTimeoutIrq |=>  // R12
		byteCount_q == ($past(demodMode) ? BYTE_DEMOD_LOAD : $past(byteReload_q)))
		else $error("byte timeout request without reload");
	a_pin34_route: assert property (!byteCtrl_q[BC_PINSEL_BIT] |=> pin34Out == $past(portData34))  // R13
		else $error("pin34 routing wrong");
	a_neg_capture: assert property (byteCapture && fallSeen |=>  // R14
		byte_capture_high_q == $past(byteCount_q) && byteCount_q == BYTE_DEMOD_LOAD)
		else $error("negative edge capture wrong");
	a_stop_keep: assert property (stopRecover && !wrCommon |=> $stable(funcField))  // R15
		else $error("field altered by stop recovery");
	a_req_and: assert property (byteTimeout && byteCtrl_q[BC_CNTMASK_BIT] |-> byteTimeoutIrq)  // R16
		else $error("request not formed from event and mask");

	c_word_cap: cover property (wordCaptureIrq);
	c_byte_tmo: cover property (byteTimeoutIrq);
	c_flag_race: cover property (wordTimeout && wrWordC);
	c_tx_pin36: cover property (!demodMode && selBit && $changed(pin36Out));
endmodule
`default_nettype wire

/* File: rtl/dctc_pkg.sv */
// Functional notes
// (R1) Common control bit 7 selects transmit or demodulation
// (R2) Bit 6: pin36 timer output, or demod input select
// (R3) Transmit bits 5:4 combine: AND, OR, NOR, NAND
// (R4) Demod bits 5:4 pick falling, rising, both edges
// (R5) Word timer edge policy: every edge or first only
// (R6) Word timeout flag set at terminal count, write-1-clear
// (R7) Clock-select field sets word timer input frequency
// (R8) Word capture request gated by capture mask
// (R9) Word timeout request gated by counter mask
// (R10) Select bit routes port data or word timer to pin35
// (R11) Byte capture request in demod, gated by mask
// (R12) Byte timeout request gated by counter mask
// (R13) Select bit routes port data or byte timer to pin34
// (R14) Byte demod: negative edge to high capture, reload all ones
// (R15) Combine/edge field kept across stop-mode recovery
// (R16) Each request is event AND its mask
`default_nettype none
package dctc_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [3:0] IDX_BYTE_CTRL   = 4'h0;
	localparam logic [3:0] IDX_COMMON_CTRL = 4'h1;
	localparam logic [3:0] IDX_WORD_CTRL   = 4'h2;
	localparam logic [3:0] IDX_BYTE_CAP_LO = 4'h3;
	localparam logic [3:0] IDX_BYTE_CAP_HI = 4'h4;
	localparam logic [3:0] IDX_WORD_CAP_LO = 4'h5;
	localparam logic [3:0] IDX_WORD_CAP_HI = 4'h6;
	localparam logic [3:0] IDX_BYTE_RELOAD = 4'h7;
	localparam logic [3:0] IDX_WORD_REL_LO = 4'h8;
	localparam logic [3:0] IDX_WORD_REL_HI = 4'h9;
	// Common control field positions
	localparam int COM_MODE_BIT   = 7;
	localparam int COM_SEL_BIT    = 6;
	localparam int COM_FUNC_LSB   = 4;
	// Byte control field positions
	localparam int BC_ENABLE_BIT  = 7;
	localparam int BC_TIMEOUT_BIT = 5;
	localparam int BC_CAPMASK_BIT = 2;
	localparam int BC_CNTMASK_BIT = 1;
	localparam int BC_PINSEL_BIT  = 0;
	// Word control field positions
	localparam int WC_ENABLE_BIT  = 7;
	localparam int WC_POLICY_BIT  = 6;
	localparam int WC_TIMEOUT_BIT = 5;
	localparam int WC_CLKSEL_LSB  = 3;
	localparam int WC_CAPMASK_BIT = 2;
	localparam int WC_CNTMASK_BIT = 1;
	localparam int WC_PINSEL_BIT  = 0;
	// Reset values
	localparam logic [7:0]  COMMON_RESET = 8'h00;
	localparam logic [7:0]  BYTE_CTRL_RESET = 8'h00;
	localparam logic [7:0]  WORD_CTRL_RESET = 8'h00;
	localparam logic [7:0]  BYTE_RELOAD_RESET = 8'hFF;
	localparam logic [15:0] WORD_RELOAD_RESET = 16'hFFFF;
	localparam logic [7:0]  BYTE_DEMOD_LOAD = 8'hFF;
	localparam logic [15:0] WORD_DEMOD_LOAD = 16'hFFFF;
	// Output combine codes, transmit mode
	typedef enum logic [1:0] {
		DCTC_COMB_AND  = 2'b00,
		DCTC_COMB_OR   = 2'b01,
		DCTC_COMB_NOR  = 2'b10,
		DCTC_COMB_NAND = 2'b11
	} dctc_comb_t;
	// Edge codes, demodulation mode
	typedef enum logic [1:0] {
		DCTC_EDGE_FALL = 2'b00,
		DCTC_EDGE_RISE = 2'b01,
		DCTC_EDGE_BOTH = 2'b10,
		DCTC_EDGE_RSVD = 2'b11
	} dctc_edge_t;
endpackage
`default_nettype wire

/* File: rtl/dctc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Three-flop pin synchroniser; output moves once stages two and three agree
module dctc_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Pin and filtered level
	input  wire logic pinIn,
	output logic      level
);
	logic stage1_q;  // Metastable stage, read only by stage2
	logic stage2_q;  // Second stage
	logic stage3_q;  // Third stage
	logic level_q;   // Accepted level

	// Shift chain and agreement filter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1_q <= 1'b0;
			stage2_q <= 1'b0;
			stage3_q <= 1'b0;
			level_q  <= 1'b0;
		end else begin
			stage1_q <= pinIn;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
			if (stage2_q == stage3_q) begin
				level_q <= stage3_q;
			end
		end
	end

	assign level = level_q;
endmodule
`default_nettype wire

/* File: sim/dctc_ir_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-side emitter: drives each demodulator input to the level the test asks for
module dctc_ir_model (
	// Clock
	input  wire logic clk,
	// Demodulator input pins
	output logic      pin31Drv,
	output logic      pin20Drv
);
	// Both lines idle high
	initial begin
		pin31Drv = 1'b1;
		pin20Drv = 1'b1;
	end
	// Move one pin just after an edge, then hold it for a while
	task automatic drive(input logic usePin20, input logic lvl, input int hold);
		@(posedge clk);
		if (usePin20) begin
			pin20Drv <= lvl;
		end else begin
			pin31Drv <= lvl;
		end
		repeat (hold) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* File: sim/dctc_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dctc_top_test;
	// Stimulus
	logic        clk, rstB, cyc, stb, we, stopRec;
	logic [31:0] adr, dat;
	logic [3:0]  sel;
	logic [2:0]  portD;
	// Design answers
	wire logic [31:0] datO;
	wire logic        ack, p34, p35, p36, bCap, bTo, wCap, wTo, pin31, pin20;
	wire logic [6:0]  mon = {p36, p35, p34, wTo, wCap, bTo, bCap};
	// Bookkeeping
	logic [6:0]  seenV;
	logic [7:0]  q;
	int          nFail, numChecks, c, p1;
	//////////////////////////////////////////////////////////////
	dctc_top u_dut (.clk(clk), .rst_b(rstB), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_dat_o(datO), .wb_ack_o(ack), .stopRecover(stopRec),
		.pin31_input(pin31), .pin20_input(pin20), .portData34(portD[0]),
		.portData35(portD[1]), .portData36(portD[2]), .pin34Out(p34),
		.pin35Out(p35), .pin36Out(p36), .byteCaptureIrq(bCap),
		.byteTimeoutIrq(bTo), .wordCaptureIrq(wCap), .wordTimeoutIrq(wTo));
	dctc_ir_model u_ir (.clk(clk), .pin31Drv(pin31), .pin20Drv(pin20));
	//////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Sticky record of pulses, sampled mid-cycle
	always @(negedge clk) begin
		seenV = seenV | mon;
	end
	// Compare and count
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		numChecks++;
		if (g !== e) begin
			nFail++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One classic bus cycle, held until ack
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {24'h000000, a};
		dat <= {24'h000000, d};
		sel <= 4'hF;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = datO[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) chk("ack", 16'h1, 16'h0);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		wb(1'b0, a, 8'h00);
		chk(nm, e, q);
	endtask
	// Cycles until the next pulse on one monitored line
	task waitPulse(input int k);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (mon[k] !== 1'b1 && c < 3000);
	endtask
	// Verdict and end of run
	task stop_test;
		$display("Checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		#400000;
		nFail++;
		stop_test;
	end
	//////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rstB, cyc, stb, we, stopRec} = 5'h00;
		{adr, dat, sel, portD, seenV} = 0;
		nFail = 0;
		numChecks = 0;
		repeat (16) @(posedge clk);
		rstB <= 1'b1;
		rd(8'h04, 8'h00, "commonReset");
		rd(8'h00, 8'h00, "byteCtrlReset");
		rd(8'h08, 8'h00, "wordCtrlReset");
		wr(8'h04, 8'hF0);
		rd(8'h04, 8'hF0, "commonRw");
		wr(8'h3C, 8'hFF);
		rd(8'h3C, 8'h00, "unmapped");
		// Ordinary port data on all three pins
		wr(8'h04, 8'h00);
		for (int v = 1; v >= 0; v--) begin
			portD <= {3{v[0]}};
			repeat (4) @(posedge clk);
			chk("portPins", {3{v[0]}}, {p36, p35, p34});
		end
		// Every combine code with both timers idle low
		for (int f = 0; f < 4; f++) begin
			wr(8'h04, {2'b01, f[1:0], 4'h0});
			repeat (4) @(posedge clk);
			chk("combine", f[1], p36);
		end
		// Byte timeout with its request enabled, byte timer on pin34
		wr(8'h1C, 8'h03);
		seenV = 0;
		wr(8'h00, 8'h83);
		waitPulse(1);
		chk("byteTimeout", 16'h1, c < 3000);
		rd(8'h00, 8'hA3, "byteFlag");
		chk("pin34Timer", 16'h1, seenV[4]);
		wr(8'h00, 8'h20);
		// Word timeout period at divide 1 then 8
		wr(8'h20, 8'h04);
		wr(8'h24, 8'h00);
		wr(8'h08, 8'h82);
		waitPulse(3);
		waitPulse(3);
		p1 = c;
		chk("divideOne", 16'h5, p1);
		wr(8'h08, 8'h9A);
		waitPulse(3);
		waitPulse(3);
		chk("clockSelect", p1 * 8, c);
		wr(8'h08, 8'h20);
		// Word timer on pin35, request masked, flag still set
		portD <= 3'h0;
		seenV = 0;
		wr(8'h08, 8'h81);
		repeat (40) @(posedge clk);
		chk("pin35Timer", 16'h1, seenV[5]);
		chk("maskedIrq", 16'h0, seenV[3]);
		rd(8'h08, 8'hA1, "wordFlagSet");
		wr(8'h08, 8'h01);
		rd(8'h08, 8'h21, "writeZeroKeeps");
		wr(8'h08, 8'h20);
		rd(8'h08, 8'h00, "writeOneClears");
		// Byte capture for the falling, rising and both edge codes
		for (int e = 0; e < 3; e++) begin
			wr(8'h04, {2'b10, e[1:0], 4'h0});
			wr(8'h00, 8'h84);
			seenV = 0;
			u_ir.drive(1'b0, 1'b0, 12);
			chk("fallCapture", e != 1, seenV[0]);
			seenV = 0;
			u_ir.drive(1'b0, 1'b1, 12);
			chk("riseCapture", e != 0, seenV[0]);
			wr(8'h00, 8'h00);
		end
		// Demodulator input taken from pin20
		wr(8'h04, 8'hC0);
		wr(8'h00, 8'h84);
		seenV = 0;
		u_ir.drive(1'b0, 1'b0, 12);
		u_ir.drive(1'b0, 1'b1, 12);
		chk("pin31Ignored", 16'h0, seenV[0]);
		u_ir.drive(1'b1, 1'b0, 12);
		chk("pin20Capture", 16'h1, seenV[0]);
		u_ir.drive(1'b1, 1'b1, 4);
		wr(8'h00, 8'h00);
		// Word edge policy: every edge, then first only
		wr(8'h04, 8'hA0);
		for (int p = 0; p < 2; p++) begin
			wr(8'h08, {1'b1, p[0], 6'h04});
			seenV = 0;
			u_ir.drive(1'b0, 1'b0, 12);
			chk("firstEdge", 16'h1, seenV[2]);
			seenV = 0;
			u_ir.drive(1'b0, 1'b1, 12);
			chk("laterEdge", p == 0, seenV[2]);
			wr(8'h08, 8'h00);
		end
		// Stop-mode recovery keeps the combine field
		wr(8'h04, 8'hE0);
		@(posedge clk);
		stopRec <= 1'b1;
		@(posedge clk);
		stopRec <= 1'b0;
		rd(8'h04, 8'h20, "stopRecover");
		stop_test;
	end
endmodule
`default_nettype wire
